/* File: mmb_pkg.sv */
// Constants shared by the management port and its internal PHY.
package mmb_pkg;
    // ------------------------------
    // Register map
    // ------------------------------
    localparam logic [7:0] CFG_OFF = 8'h04;
    localparam logic [7:0] ACC_OFF = 8'h08;
    localparam int         AW      = 8;

    // ------------------------------
    // Field positions
    // ------------------------------
    localparam int CFG_EXT_BIT = 12;
    localparam int CFG_DIS_BIT = 9;
    localparam int ACC_CLK_BIT = 6;
    localparam int ACC_DIR_BIT = 5;
    localparam int ACC_DAT_BIT = 4;

    // ------------------------------
    // Values after reset
    // ------------------------------
    localparam logic EXT_RST = 1'b0;
    localparam logic CLK_RST = 1'b0;
    localparam logic DIR_RST = 1'b0;
    localparam logic DAT_RST = 1'b0;

    // ------------------------------
    // Management frame
    // ------------------------------
    localparam logic [4:0] IPHY_ADDR = 5'h1f;
    localparam int         NREG      = 32;
    localparam int         REG_W     = 16;
    localparam int         MAX_DEVS  = 32;
    localparam logic [5:0] PRE_LEN   = 6'h20;
    localparam logic [1:0] OP_RD     = 2'b10;
    localparam logic [1:0] OP_WR     = 2'b01;
    localparam logic [5:0] FLD_LAST  = 6'h04;
    localparam logic [5:0] PAIR_LAST = 6'h01;
    localparam logic [5:0] DAT_LAST  = 6'h0f;
endpackage

/* File: mmb_iphy.sv */
// Internal PHY management slave holding thirty-two 16-bit registers.
`timescale 1ns/1ns
module mmb_iphy #(
    parameter logic [4:0] PHY_ADDR = mmb_pkg::IPHY_ADDR,
    parameter int         NREG     = mmb_pkg::NREG
) (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic ce,
    // Management line
    input  wire logic enable,
    input  wire logic mdc_rise,
    input  wire logic mdio_in,
    output logic      mdio_o,
    output logic      mdio_oe
);
    typedef enum logic [2:0] {
        ST_PRE, ST_START, ST_OP, ST_PA, ST_RA, ST_TA, ST_DATA
    } mmb_frame_e;

    mmb_frame_e  st_q;
    logic [5:0]  cnt_q;
    logic [15:0] sh_q;
    logic [15:0] tx_q;
    logic        rd_q;
    logic        hit_q;
    logic [4:0]  ra_q;
    logic [15:0] regs_q [NREG];
    logic        step;
    logic        wr_fire;
    logic [15:0] wdata;
    logic [4:0]  field;

    if (NREG != mmb_pkg::NREG) begin : g_chk
        $error("Register count must be thirty-two.");
    end

    assign step    = ce && mdc_rise;
    assign wdata   = {sh_q[14:0], mdio_in};
    assign field   = {sh_q[3:0], mdio_in};
    assign wr_fire = step && st_q == ST_DATA &&
                     cnt_q == mmb_pkg::DAT_LAST && !rd_q && hit_q;

    // ------------------------------
    // Frame sequencer
    // ------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q  <= ST_PRE;
            cnt_q <= 6'h00;
            sh_q  <= 16'h0000;
            rd_q  <= 1'b0;
            hit_q <= 1'b0;
            ra_q  <= 5'h00;
        end else if (step) begin
            sh_q  <= wdata;
            cnt_q <= cnt_q + 6'h01;
            case (st_q)
                ST_PRE: begin
                    if (mdio_in) begin
                        if (cnt_q == mmb_pkg::PRE_LEN) begin
                            cnt_q <= cnt_q;
                        end
                    end else begin
                        cnt_q <= 6'h00;
                        if (cnt_q == mmb_pkg::PRE_LEN) begin
                            st_q <= ST_START;
                        end
                    end
                end
                ST_START: begin
                    cnt_q <= 6'h00;
                    st_q  <= mdio_in ? ST_OP : ST_PRE;
                end
                ST_OP: begin
                    if (cnt_q == mmb_pkg::PAIR_LAST) begin
                        cnt_q <= 6'h00;
                        rd_q  <= field[1:0] == mmb_pkg::OP_RD;
                        if (field[1:0] == mmb_pkg::OP_RD ||
                            field[1:0] == mmb_pkg::OP_WR) begin
                            st_q <= ST_PA;
                        end else begin
                            st_q <= ST_PRE;
                        end
                    end
                end
                ST_PA: begin
                    if (cnt_q == mmb_pkg::FLD_LAST) begin
                        cnt_q <= 6'h00;
                        hit_q <= enable && field == PHY_ADDR;
                        st_q  <= ST_RA;
                    end
                end
                ST_RA: begin
                    if (cnt_q == mmb_pkg::FLD_LAST) begin
                        cnt_q <= 6'h00;
                        ra_q  <= field;
                        st_q  <= ST_TA;
                    end
                end
                ST_TA: begin
                    if (cnt_q == mmb_pkg::PAIR_LAST) begin
                        cnt_q <= 6'h00;
                        st_q  <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (cnt_q == mmb_pkg::DAT_LAST) begin
                        cnt_q <= 6'h00;
                        st_q  <= ST_PRE;
                    end
                end
                default: begin
                    cnt_q <= 6'h00;
                    st_q  <= ST_PRE;
                end
            endcase
        end
    end

    // ------------------------------
    // Register array
    // ------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NREG; i++) begin
                regs_q[i] <= 16'h0000;
            end
        end else if (wr_fire) begin
            regs_q[ra_q] <= wdata;
        end
    end

    // ------------------------------
    // Read data driver
    // ------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mdio_o  <= 1'b0;
            mdio_oe <= 1'b0;
            tx_q    <= 16'h0000;
        end else if (ce && !enable) begin
            mdio_oe <= 1'b0;
        end else if (step) begin
            if (st_q == ST_TA && cnt_q == 6'h00 && rd_q && hit_q) begin
                mdio_oe <= 1'b1;
                mdio_o  <= 1'b0;
                tx_q    <= regs_q[ra_q];
            end else if (mdio_oe && (st_q == ST_TA ||
                         cnt_q != mmb_pkg::DAT_LAST)) begin
                mdio_o <= tx_q[15];
                tx_q   <= {tx_q[14:0], 1'b0};
            end else begin
                mdio_oe <= 1'b0;
                mdio_o  <= 1'b0;
            end
        end
    end

    // ------------------------------
    // Checks
    // ------------------------------
    chk_ta_release: assert property (
        @(posedge hclk) disable iff (!hresetn)
        st_q == ST_TA && cnt_q == 6'h00 |-> !mdio_oe)
        else $error("Line driven on first turnaround bit.");

    chk_ta_zero: assert property (
        @(posedge hclk) disable iff (!hresetn)
        step && st_q == ST_TA && cnt_q == 6'h00 && rd_q && hit_q
        && enable |=> mdio_oe && !mdio_o)
        else $error("Second turnaround bit not driven low.");

    chk_preamble: assert property (
        @(posedge hclk) disable iff (!hresetn)
        step && st_q == ST_PRE && cnt_q != mmb_pkg::PRE_LEN
        |=> st_q == ST_PRE)
        else $error("Frame started without full preamble.");

    chk_addr_hit: assert property (
        @(posedge hclk) disable iff (!hresetn)
        step && st_q == ST_PA && cnt_q == mmb_pkg::FLD_LAST
        && field == PHY_ADDR && enable |=> hit_q)
        else $error("Own address not recognised.");

    chk_reg_write: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_fire |=> regs_q[$past(ra_q)] == $past(wdata))
        else $error("Write frame did not update register.");
endmodule

/* File: mmb_port.sv */
// Bit-banged management port with external PHY routing, AHB-Lite slave.
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ns
module mmb_port #(
    parameter logic [4:0] IPHY_ADDR = mmb_pkg::IPHY_ADDR
) (
    // Clock, reset and enable
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // MAC routing
    output logic             external_phy_select_route,
    output logic             internal_phy_disabled,
    // Management pins
    output logic             mdc,
    input  wire logic        mdio_i,
    output logic             mdio_o,
    output logic             mdio_oe
);
    // ------------------------------
    // Declarations
    // ------------------------------
    logic                   wr_pend_q;
    logic [mmb_pkg::AW-1:0] wr_addr_q;
    logic [31:0]            rdata_q;
    logic                   ext_sel_q;
    logic                   internal_phy_disabled_q;
    logic                   clk_q;
    logic                   clk_prev_q;
    logic                   dir_q;
    logic                   dat_q;
    logic                   sync1_q;
    logic                   sync2_q;
    logic                   pin_o_q;
    logic                   pin_oe_q;
    logic                   iphy_o;
    logic                   iphy_oe;
    logic                   mdc_rise;
    logic                   addr_phase;
    logic                   wr_do;

    if (mmb_pkg::MAX_DEVS != 32) begin : g_chk
        $error("Shared line limit must be thirty-two devices.");
    end

    // ------------------------------
    // Read multiplexer
    // ------------------------------
    function automatic logic [31:0] rd_word(
        input logic [mmb_pkg::AW-1:0] a
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            mmb_pkg::CFG_OFF: begin
                w[mmb_pkg::CFG_EXT_BIT] = ext_sel_q;
                w[mmb_pkg::CFG_DIS_BIT] = internal_phy_disabled_q;
            end
            mmb_pkg::ACC_OFF: begin
                w[mmb_pkg::ACC_CLK_BIT] = clk_q;
                w[mmb_pkg::ACC_DIR_BIT] = dir_q;
                w[mmb_pkg::ACC_DAT_BIT] = dir_q ? dat_q : sync2_q;
            end
            default: begin
                w = 32'h0000_0000;
            end
        endcase
        return w;
    endfunction

    // ------------------------------
    // Bus slave
    // ------------------------------
    assign addr_phase = hsel && htrans[1] && hready && ce;
    assign wr_do      = wr_pend_q && ce;
    assign hreadyout  = ce;
    assign hresp      = 1'b0;
    assign hrdata     = rdata_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
        end else if (ce) begin
            wr_pend_q <= addr_phase && hwrite;
            wr_addr_q <= haddr[mmb_pkg::AW-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            rdata_q <= rd_word(haddr[mmb_pkg::AW-1:0]);
        end
    end

    // ------------------------------
    // Configuration register
    // ------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_sel_q <= mmb_pkg::EXT_RST;
        end else if (wr_do && wr_addr_q == mmb_pkg::CFG_OFF) begin
            ext_sel_q <= hwdata[mmb_pkg::CFG_EXT_BIT];
        end
    end

    // The internal PHY is shut off, one enabled cycle late, for as long as the external MII is used.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            internal_phy_disabled_q <= mmb_pkg::EXT_RST;
        end else if (ce) begin
            internal_phy_disabled_q <= ext_sel_q;
        end
    end

    assign external_phy_select_route         = ext_sel_q;
    assign internal_phy_disabled = internal_phy_disabled_q;

    // ------------------------------
    // Access register
    // ------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_q <= mmb_pkg::CLK_RST;
            dir_q <= mmb_pkg::DIR_RST;
            dat_q <= mmb_pkg::DAT_RST;
        end else if (wr_do && wr_addr_q == mmb_pkg::ACC_OFF) begin
            clk_q <= hwdata[mmb_pkg::ACC_CLK_BIT];
            dir_q <= hwdata[mmb_pkg::ACC_DIR_BIT];
            dat_q <= hwdata[mmb_pkg::ACC_DAT_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_prev_q <= mmb_pkg::CLK_RST;
        end else if (ce) begin
            clk_prev_q <= clk_q;
        end
    end

    assign mdc      = clk_q;
    assign mdc_rise = clk_q && !clk_prev_q;

    // ------------------------------
    // Data pin synchroniser
    // ------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end else if (ce) begin
            sync1_q <= mdio_i;
            sync2_q <= sync1_q;
        end
    end

    // ------------------------------
    // Pin drivers
    // ------------------------------
    // The software drive takes precedence over the internal PHY if both
    // are enabled, so a misbehaving frame cannot lock software out.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_o_q  <= 1'b0;
            pin_oe_q <= 1'b0;
        end else if (ce) begin
            pin_oe_q <= dir_q || iphy_oe;
            pin_o_q  <= dir_q ? dat_q : iphy_o;
        end
    end

    assign mdio_o  = pin_o_q;
    assign mdio_oe = pin_oe_q;

    // ------------------------------
    // Internal PHY on the shared line
    // ------------------------------
    mmb_iphy #(
        .PHY_ADDR (IPHY_ADDR),
        .NREG     (mmb_pkg::NREG)
    ) u_iphy (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .ce       (ce),
        .enable   (!internal_phy_disabled_q),
        .mdc_rise (mdc_rise),
        .mdio_in  (sync2_q),
        .mdio_o   (iphy_o),
        .mdio_oe  (iphy_oe)
    );

    // ------------------------------
    // Checks
    // ------------------------------
    chk_ext_route: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_do && wr_addr_q == mmb_pkg::CFG_OFF
        |=> external_phy_select_route == $past(hwdata[mmb_pkg::CFG_EXT_BIT]))
        else $error("External select not taken from write.");

    chk_phy_disable: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ce && external_phy_select_route ##1 ce |=> internal_phy_disabled
        && !iphy_oe)
        else $error("Internal PHY not disabled.");

    chk_mdc_follow: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_do && wr_addr_q == mmb_pkg::ACC_OFF
        |=> mdc == $past(hwdata[mmb_pkg::ACC_CLK_BIT]))
        else $error("Clock pin does not follow clock bit.");

    chk_pin_drive: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ce && dir_q |=> mdio_oe && mdio_o == $past(dat_q))
        else $error("Data pin not driven from data bit.");

    chk_pin_release: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ce && !dir_q && !iphy_oe |=> !mdio_oe)
        else $error("Data pin not released.");

    chk_pin_capture: assert property (
        @(posedge hclk) disable iff (!hresetn)
        addr_phase && !hwrite && !dir_q
        && haddr[mmb_pkg::AW-1:0] == mmb_pkg::ACC_OFF
        |=> hrdata[mmb_pkg::ACC_DAT_BIT] == $past(sync2_q))
        else $error("Data bit does not show pin level.");

    // ------------------------------
    // Bus and pin checks
    // ------------------------------
    default clocking cb @(posedge hclk);
    endclocking

    default disable iff (!hresetn);

    chk_ready_okay: assert property (
        hreadyout == ce && !hresp)
        else $error("Bus answer not ready or not okay.");

    chk_dis_lag: assert property (
        ce |=> internal_phy_disabled == $past(external_phy_select_route))
        else $error("Disabled bit does not follow select.");

    chk_cfg_read: assert property (
        addr_phase && !hwrite &&
        haddr[mmb_pkg::AW-1:0] == mmb_pkg::CFG_OFF
        |=> hrdata[mmb_pkg::CFG_DIS_BIT] == $past(internal_phy_disabled_q))
        else $error("Disabled bit not readable.");

    chk_acc_read: assert property (
        addr_phase && !hwrite && dir_q &&
        haddr[mmb_pkg::AW-1:0] == mmb_pkg::ACC_OFF
        |=> hrdata[mmb_pkg::ACC_DAT_BIT] == $past(dat_q))
        else $error("Data bit does not read back.");

    chk_clk_read: assert property (
        addr_phase && !hwrite &&
        haddr[mmb_pkg::AW-1:0] == mmb_pkg::ACC_OFF
        |=> hrdata[mmb_pkg::ACC_CLK_BIT] == $past(clk_q))
        else $error("Clock bit does not read back.");

    chk_dir_read: assert property (
        addr_phase && !hwrite &&
        haddr[mmb_pkg::AW-1:0] == mmb_pkg::ACC_OFF
        |=> hrdata[mmb_pkg::ACC_DIR_BIT] == $past(dir_q))
        else $error("Direction bit does not read back.");

    chk_unmapped_zero: assert property (
        addr_phase && !hwrite &&
        haddr[mmb_pkg::AW-1:0] != mmb_pkg::CFG_OFF &&
        haddr[mmb_pkg::AW-1:0] != mmb_pkg::ACC_OFF
        |=> hrdata == 32'h0000_0000)
        else $error("Unmapped offset reads nonzero.");

    chk_mdc_hold: assert property (
        !(wr_do && wr_addr_q == mmb_pkg::ACC_OFF) |=> $stable(mdc))
        else $error("Clock pin moved without a write.");

    chk_route_hold: assert property (
        !(wr_do && wr_addr_q == mmb_pkg::CFG_OFF)
        |=> $stable(external_phy_select_route))
        else $error("Route moved without a write.");

    chk_oe_source: assert property (
        ce |=> mdio_oe == ($past(dir_q) || $past(iphy_oe)))
        else $error("Pin enable has a wrong source.");

    chk_out_source: assert property (
        ce && !dir_q |=> mdio_o == $past(iphy_o))
        else $error("Pin value not from internal PHY.");

    chk_dir_write: assert property (
        wr_do && wr_addr_q == mmb_pkg::ACC_OFF
        |=> dir_q == $past(hwdata[mmb_pkg::ACC_DIR_BIT]))
        else $error("Direction bit not taken from write.");

    chk_dat_write: assert property (
        wr_do && wr_addr_q == mmb_pkg::ACC_OFF
        |=> dat_q == $past(hwdata[mmb_pkg::ACC_DAT_BIT]))
        else $error("Data bit not taken from write.");

    chk_iphy_off: assert property (
        internal_phy_disabled |=> !iphy_oe)
        else $error("Disabled internal PHY drives line.");

    chk_rdata_hold: assert property (
        !(addr_phase && !hwrite)
        |=> $stable(hrdata))
        else $error("Read data moved without a read.");
endmodule

/* File: mmb_external_phy_select.sv */
// Behavioural external PHY that answers management frames at one address.
`timescale 1ns/1ns
module mmb_external_phy_select #(
    parameter logic [4:0] ADDR = 5'h03
) (
    // Management pins
    input  wire logic mdc,
    input  wire logic mdio,
    output logic      drv_o,
    output logic      drv_oe
);
    logic [15:0] regs [32];
    logic [12:0] hdr;
    int          ones;

    initial begin
        drv_o = 1'b1;
        drv_oe = 1'b0;
        foreach (regs[i]) regs[i] = 16'h0000;
        forever begin
            ones = 0;
            forever begin
                @(posedge mdc);
                if (mdio === 1'b0 && ones >= 32) break;
                ones = (mdio === 1'b1) ? ones + 1 : 0;
            end
            for (int i = 12; i >= 0; i--) begin
                @(posedge mdc);
                hdr[i] = mdio;
            end
            if (hdr[12] === 1'b1 && hdr[9:5] == ADDR) begin
                if (hdr[11:10] == mmb_pkg::OP_RD) begin
                    // First turnaround bit stays released.
                    @(posedge mdc);
                    #4 drv_oe = 1'b1;
                    drv_o = 1'b0;
                    for (int i = 15; i >= 0; i--) begin
                        @(posedge mdc);
                        #4 drv_o = regs[hdr[4:0]][i];
                    end
                    @(posedge mdc);
                    #4 drv_oe = 1'b0;
                    drv_o = 1'b1;
                end else if (hdr[11:10] == mmb_pkg::OP_WR) begin
                    repeat (2) @(posedge mdc);
                    for (int i = 15; i >= 0; i--) begin
                        @(posedge mdc);
                        regs[hdr[4:0]][i] = mdio;
                    end
                end
            end
        end
    end
endmodule

/* File: tb.sv */
// Self-checking bench for the bit-banged management port.
`timescale 1ns/1ns
module tb;
    // ------------------------------
    // Signals
    // ------------------------------
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        external_phy_select_route;
    logic        internal_phy_disabled;
    logic        mdc;
    logic        mdio_o;
    logic        mdio_oe;
    logic        ext_o;
    logic        ext_oe;
    logic        mdio_w;
    logic [31:0] q;
    logic [17:0] r;
    int          num_errors;
    int          n_compared;

    // The shared line has a pull-up; it reads high when released.
    assign mdio_w = mdio_oe ? mdio_o : (ext_oe ? ext_o : 1'b1);

    mmb_port mmb_port_i (
        .hclk                  (hclk),
        .hresetn               (hresetn),
        .ce                    (1'b1),
        .hsel                  (hsel),
        .haddr                 (haddr),
        .htrans                (htrans),
        .hwrite                (hwrite),
        .hsize                 (3'h2),
        .hready                (hreadyout),
        .hwdata                (hwdata),
        .hreadyout             (hreadyout),
        .hresp                 (hresp),
        .hrdata                (hrdata),
        .external_phy_select_route         (external_phy_select_route),
        .internal_phy_disabled (internal_phy_disabled),
        .mdc                   (mdc),
        .mdio_i                (mdio_w),
        .mdio_o                (mdio_o),
        .mdio_oe               (mdio_oe)
    );

    mmb_external_phy_select #(.ADDR(5'h03)) mmb_external_phy_select_i (
        .mdc    (mdc),
        .mdio   (mdio_w),
        .drv_o  (ext_o),
        .drv_oe (ext_oe)
    );

    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    // ------------------------------
    // Tasks
    // ------------------------------
    task automatic results();
        if (num_errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk_word(input string nm, input logic [31:0] exp,
                            input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chk_pin(input string nm, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %b seen %b", nm, exp, got);
        end
    endtask

    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (hreadyout !== 1'b1) begin
            num_errors++;
            results();
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rq);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        htrans <= 2'b10;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        rq = hrdata;
    endtask

    // One access write plus a pad cycle gives a 32 ns half period of the 64 ns management clock.
    task automatic acc(input logic c, input logic dir, input logic dat);
        logic [31:0] x;
        bus(1'b1, mmb_pkg::ACC_OFF, {25'h0, c, dir, dat, 4'h0}, x);
        @(posedge hclk);
    endtask

    task automatic send_bits(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            acc(1'b0, 1'b1, v[i]);
            acc(1'b1, 1'b1, v[i]);
        end
    endtask

    task automatic frame_wr(input logic [1:0] op, input logic [4:0] phy,
                            input logic [4:0] rg, input logic [15:0] d);
        send_bits(32'hffffffff, 32);
        send_bits({2'b01, op, phy, rg, 2'b10, d}, 32);
    endtask

    task automatic frame_rd(input logic [4:0] phy, input logic [4:0] rg,
                            output logic [17:0] rb);
        logic [31:0] x;
        send_bits(32'hffffffff, 32);
        send_bits({18'h0, 2'b01, mmb_pkg::OP_RD, phy, rg}, 14);
        for (int i = 17; i >= 0; i--) begin
            acc(1'b0, 1'b0, 1'b0);
            bus(1'b0, mmb_pkg::ACC_OFF, 32'h0, x);
            rb[i] = x[4];
            acc(1'b1, 1'b0, 1'b0);
        end
    endtask

    // ------------------------------
    // Sequence
    // ------------------------------
    initial begin
        repeat (100000) @(posedge hclk);
        num_errors++;
        results();
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        num_errors = 0;
        n_compared = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, mmb_pkg::CFG_OFF, 32'h0, q);
        chk_word("cfg_reset", 32'h00000000, q);
        bus(1'b0, mmb_pkg::ACC_OFF, 32'h0, q);
        chk_word("acc_reset", 32'h00000010, q);
        bus(1'b1, 8'h10, 32'hffffffff, q);
        bus(1'b0, 8'h10, 32'h0, q);
        chk_word("unmapped", 32'h00000000, q);
        chk_pin("hresp_okay", 1'b0, hresp);
        chk_pin("mdc_reset", 1'b0, mdc);
        chk_pin("oe_reset", 1'b0, mdio_oe);
        acc(1'b1, 1'b1, 1'b0);
        @(negedge hclk);
        chk_pin("mdc_high", 1'b1, mdc);
        chk_pin("oe_drive", 1'b1, mdio_oe);
        chk_pin("dat_low", 1'b0, mdio_o);
        bus(1'b0, mmb_pkg::ACC_OFF, 32'h0, q);
        chk_word("acc_60", 32'h00000060, q);
        acc(1'b0, 1'b1, 1'b1);
        @(negedge hclk);
        chk_pin("mdc_low", 1'b0, mdc);
        chk_pin("dat_high", 1'b1, mdio_o);
        acc(1'b0, 1'b0, 1'b0);
        @(negedge hclk);
        chk_pin("oe_release", 1'b0, mdio_oe);
        bus(1'b0, mmb_pkg::ACC_OFF, 32'h0, q);
        chk_word("acc_pin", 32'h00000010, q);
        frame_wr(mmb_pkg::OP_WR, mmb_pkg::IPHY_ADDR, 5'h03, 16'ha5c3);
        frame_rd(mmb_pkg::IPHY_ADDR, 5'h03, r);
        chk_word("iphy_rd", {14'h0, 2'b10, 16'ha5c3}, {14'h0, r});
        frame_wr(mmb_pkg::OP_WR, mmb_pkg::IPHY_ADDR, 5'h1f, 16'h8001);
        frame_rd(mmb_pkg::IPHY_ADDR, 5'h1f, r);
        chk_word("iphy_r31", {14'h0, 2'b10, 16'h8001}, {14'h0, r});
        frame_wr(mmb_pkg::OP_WR, 5'h03, 5'h07, 16'h3c5a);
        frame_rd(5'h03, 5'h07, r);
        chk_word("ext_rd", {14'h0, 2'b10, 16'h3c5a}, {14'h0, r});
        frame_wr(2'b11, mmb_pkg::IPHY_ADDR, 5'h03, 16'h0000);
        frame_rd(mmb_pkg::IPHY_ADDR, 5'h03, r);
        chk_word("bad_op", {14'h0, 2'b10, 16'ha5c3}, {14'h0, r});
        bus(1'b1, mmb_pkg::CFG_OFF, 32'h00000200, q);
        bus(1'b0, mmb_pkg::CFG_OFF, 32'h0, q);
        chk_word("cfg_ro", 32'h00000000, q);
        bus(1'b1, mmb_pkg::CFG_OFF, 32'h00001000, q);
        repeat (2) @(negedge hclk);
        chk_pin("route", 1'b1, external_phy_select_route);
        chk_pin("disabled", 1'b1, internal_phy_disabled);
        bus(1'b0, mmb_pkg::CFG_OFF, 32'h0, q);
        chk_word("cfg_ext", 32'h00001200, q);
        frame_rd(mmb_pkg::IPHY_ADDR, 5'h03, r);
        chk_word("iphy_off", 32'h0003ffff, {14'h0, r});
        frame_rd(5'h03, 5'h07, r);
        chk_word("ext_sel", {14'h0, 2'b10, 16'h3c5a}, {14'h0, r});
        results();
    end
endmodule
